// ==== hdl/etsm_defines.svh ====
// ****************************************************************
// Summary of operation
// ****************************************************************
`ifndef ETSM_DEFINES_SVH
`define ETSM_DEFINES_SVH

// ****************************************************************
// register map
// ****************************************************************
`define ETSM_SYNC_MUX_ADDR  12'h109
`define ETSM_STAT_ADDR      12'h1f0
`define ETSM_SYNC_MUX_RESET 8'h00
`define ETSM_EBIT_SRC_HI    7
`define ETSM_EBIT_SRC_LO    6
`define ETSM_MF_OPT_BIT     5
`define ETSM_TSEL_BIT       4
`define ETSM_DLINK_SRC_HI   3
`define ETSM_DLINK_SRC_LO   2
`define ETSM_CRC_SRC_BIT    1
`define ETSM_ALIGN_SRC_BIT  0
`define ETSM_STAT_OVF_BIT  0
`define ETSM_STAT_AVL_BIT  1

// ****************************************************************
// frame layout
// ****************************************************************
`define ETSM_ALIGN_WORD    7'h1b
`define ETSM_E_FRAME_A     4'hd
`define ETSM_E_FRAME_B     4'hf
`define ETSM_E_POS         3'h0
`define ETSM_NFAS_ONE_POS  3'h1
`define ETSM_SA4_POS       3'h3
`define ETSM_LAST_BIT      8'hff

`endif

// ==== hdl/etsm_pkg.sv ====
package etsm_pkg;

    // link alignment state
    typedef enum logic {
        ETSM_HUNT,
        ETSM_RUN
    } etsm_lnk_state_t;

    // system clock domain state
    typedef struct packed {
        logic [7:0] sync_mux;
        logic       ovf;
        logic       err_tgl;
        logic       ovf_seen;
        logic [7:0] rdata;
        logic       rdy;
    } etsm_sys_t;

    // link clock domain state
    typedef struct packed {
        etsm_lnk_state_t state;
        logic [7:0]      bit_cnt;
        logic [3:0]      frm_cnt;
        logic            pend;
        logic [7:0]      sh;
        logic            fs_out;
        logic            fs_oe_n;
        logic            mfs_out;
        logic            mfs_oe_n;
        logic            err_seen;
        logic            ovf_tgl;
        logic            tsel_prev;
        logic            wr_valid;
        logic [8:0]      wr_data;
    } etsm_lnk_t;

endpackage

// ==== hdl/etsm_sync.sv ====
`timescale 1ns/100ps
// two-stage level synchroniser; only the second stage is visible
module etsm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds nothing but the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ==== hdl/etsm_fifo.sv ====
`timescale 1ns/100ps
// dual-clock fifo, gray pointers, registered read stage
module etsm_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    input  wire logic         wr_clk,
    input  wire logic         rd_clk,
    input  wire logic         rst,
    input  wire logic         wr_valid,
    input  wire logic [W-1:0] wr_data,
    output logic              wr_ready,
    output logic              rd_valid,
    output logic      [W-1:0] rd_data,
    input  wire logic         rd_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];
    logic [AW:0]   wbin_q;
    logic [AW:0]   wgray_q;
    logic [AW:0]   rbin_q;
    logic [AW:0]   rgray_q;
    logic [AW:0]   rgray_w;
    logic [AW:0]   wgray_r;
    logic          full;
    logic          empty;
    logic          push;
    logic          pop;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    // full when pointers differ only in the two top gray bits
    assign full     = (wgray_q == {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
    assign empty    = (rgray_q == wgray_r);
    assign wr_ready = !full;
    assign push     = wr_valid && !full;
    assign pop      = !empty && (!rd_valid || rd_ready);

    // write side
    always_ff @(posedge wr_clk or posedge rst) begin
        if (rst) begin
            wbin_q  <= '0;
            wgray_q <= '0;
        end else if (push) begin
            wbin_q  <= wbin_q + 1'b1;
            wgray_q <= to_gray(wbin_q + 1'b1);
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge wr_clk) begin
        if (push) begin
            mem[wbin_q[AW-1:0]] <= wr_data;
        end
    end

    // read side with output register
    always_ff @(posedge rd_clk or posedge rst) begin
        if (rst) begin
            rbin_q   <= '0;
            rgray_q  <= '0;
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else if (pop) begin
            rbin_q   <= rbin_q + 1'b1;
            rgray_q  <= to_gray(rbin_q + 1'b1);
            rd_data  <= mem[rbin_q[AW-1:0]];
            rd_valid <= 1'b1;
        end else if (rd_ready) begin
            rd_valid <= 1'b0;
        end
    end

    etsm_sync #(.W(AW + 1)) u_w2r (
        .clk (rd_clk),
        .rst (rst),
        .d   (wgray_q),
        .q   (wgray_r)
    );

    etsm_sync #(.W(AW + 1)) u_r2w (
        .clk (wr_clk),
        .rst (rst),
        .d   (rgray_q),
        .q   (rgray_w)
    );
endmodule

// ==== hdl/etsm_top.sv ====
`timescale 1ns/100ps
`include "etsm_defines.svh"
module etsm_top #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        cpu_cs,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [11:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    output logic             cpu_rdy,
    input  wire logic        backplane_high_speed,
    input  wire logic        rx_crc_error,
    input  wire logic        tx_serial_clock_pin,
    input  wire logic        tx_serial_data_pin,
    input  wire logic        tx_overhead_data_pin,
    input  wire logic        hdlc_tx_dl_bit,
    input  wire logic        tx_frame_sync_pin_in,
    output logic             tx_frame_sync_pin_out,
    output logic             tx_frame_sync_pin_oe_n,
    input  wire logic        tx_multiframe_sync_pin_in,
    output logic             tx_multiframe_sync_pin_out,
    output logic             tx_multiframe_sync_pin_oe_n,
    output logic      [7:0]  frame_data,
    output logic             frame_first,
    output logic             frame_valid,
    input  wire logic        frame_ready
);
    localparam logic [6:0] ALIGN_WORD = `ETSM_ALIGN_WORD;

    etsm_pkg::etsm_sys_t sys_q;
    etsm_pkg::etsm_sys_t sys_d;
    etsm_pkg::etsm_lnk_t ln_q;
    etsm_pkg::etsm_lnk_t ln_d;

    logic [8:0] cfg_s;
    logic [3:0] pin_s;
    logic       ovf_tgl_s;
    logic       fifo_ready;
    logic       fifo_valid;
    logic [8:0] fifo_data;

    // decoded link-side configuration
    logic       cfg_hs;
    logic [1:0] cfg_ebit;
    logic       cfg_mfopt;
    logic       cfg_tsel;
    logic [1:0] cfg_dlink;
    logic       cfg_align;
    logic       err_tgl_s;
    logic       fs_s;
    logic       mfs_s;
    logic       ser_s;
    logic       ovh_s;

    // link combinational terms
    logic       mf_mark;
    logic       start;
    logic [7:0] cur_bit;
    logic [3:0] cur_frm;
    logic       e_slot;
    logic       dl_bit;
    logic       b;
    logic       consume;
    logic       new_err;
    logic       ovf_evt;

    // ****************************************************************
    // system clock domain: register port
    // ****************************************************************

    // writes update, reads capture; overflow set beats the clear
    always_comb begin
        sys_d       = sys_q;
        sys_d.rdy   = 1'b0;
        ovf_evt     = (ovf_tgl_s != sys_q.ovf_seen);
        sys_d.ovf_seen = ovf_tgl_s;
        if (rx_crc_error) begin
            sys_d.err_tgl = ~sys_q.err_tgl;
        end
        if (cpu_cs && cpu_wr) begin
            sys_d.rdy = 1'b1;
            if (cpu_addr == `ETSM_SYNC_MUX_ADDR) begin
                sys_d.sync_mux = cpu_wdata;
            end
            if (cpu_addr == `ETSM_STAT_ADDR &&
                cpu_wdata[`ETSM_STAT_OVF_BIT]) begin
                sys_d.ovf = 1'b0;
            end
        end else if (cpu_cs && cpu_rd) begin
            sys_d.rdy = 1'b1;
            case (cpu_addr)
                `ETSM_SYNC_MUX_ADDR: begin
                    sys_d.rdata = sys_q.sync_mux;
                end
                `ETSM_STAT_ADDR: begin
                    sys_d.rdata = {6'h00, fifo_valid, sys_q.ovf};
                end
                default: begin
                    sys_d.rdata = 8'h00;
                end
            endcase
        end
        if (ovf_evt) begin
            sys_d.ovf = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sys_q     <= '0;
            sys_q.sync_mux <= `ETSM_SYNC_MUX_RESET;
        end else begin
            sys_q <= sys_d;
        end
    end

    assign cpu_rdata = sys_q.rdata;
    assign cpu_rdy   = sys_q.rdy;

    // ****************************************************************
    // crossings
    // ****************************************************************

    // config is quasi-static: change it only while the link is idle
    etsm_sync #(.W(9)) u_cfg_sync (
        .clk (tx_serial_clock_pin),
        .rst (rst),
        .d   ({sys_q.err_tgl, backplane_high_speed,
               sys_q.sync_mux[7:2],
               sys_q.sync_mux[`ETSM_ALIGN_SRC_BIT]}),
        .q   (cfg_s)
    );

    etsm_sync #(.W(4)) u_pin_sync (
        .clk (tx_serial_clock_pin),
        .rst (rst),
        .d   ({tx_frame_sync_pin_in, tx_multiframe_sync_pin_in,
               tx_serial_data_pin, tx_overhead_data_pin}),
        .q   (pin_s)
    );

    etsm_sync #(.W(1)) u_ovf_sync (
        .clk (sys_clk),
        .rst (rst),
        .d   (ln_q.ovf_tgl),
        .q   (ovf_tgl_s)
    );

    assign err_tgl_s = cfg_s[8];
    assign cfg_hs    = cfg_s[7];
    assign cfg_ebit  = cfg_s[6:5];
    assign cfg_mfopt = cfg_s[4];
    assign cfg_tsel  = cfg_s[3];
    assign cfg_dlink = cfg_s[2:1];
    assign cfg_align = cfg_s[0];
    assign fs_s      = pin_s[3];
    assign mfs_s     = pin_s[2];
    assign ser_s     = pin_s[1];
    assign ovh_s     = pin_s[0];

    // ****************************************************************
    // link clock domain: timing and overhead insertion
    // ****************************************************************

    // frame/multiframe timing, bit substitution, byte packing
    always_comb begin
        ln_d    = ln_q;
        // fast modes: pin is a clock, so only the option can mark
        mf_mark = cfg_tsel && (cfg_hs ? (cfg_mfopt && fs_s) : mfs_s);
        start   = cfg_tsel && (fs_s || mf_mark);
        cur_bit = start ? 8'h00 : ln_q.bit_cnt;
        if (mf_mark) begin
            cur_frm = 4'h0;
        end else if (start && ln_q.bit_cnt != 8'h00) begin
            cur_frm = ln_q.frm_cnt + 4'h1;
        end else begin
            cur_frm = ln_q.frm_cnt;
        end
        e_slot = (cur_bit == 8'h00) &&
                 (cur_frm == `ETSM_E_FRAME_A || cur_frm == `ETSM_E_FRAME_B);
        // three data link sources; 11 falls back to serial input
        case (cfg_dlink)
            2'b01:   dl_bit = hdlc_tx_dl_bit;
            2'b10:   dl_bit = ovh_s;
            default: dl_bit = ser_s;
        endcase
        b       = ser_s; // pass-through when alignment is external
        consume = 1'b0;
        if (ln_q.state == etsm_pkg::ETSM_RUN && !cfg_align &&
            cur_bit[7:3] == 5'h00) begin
            if (!cur_frm[0]) begin
                if (cur_bit[2:0] != 3'h0) begin
                    b = ALIGN_WORD[3'h7 - cur_bit[2:0]];
                end
            end else if (cur_bit[2:0] == `ETSM_NFAS_ONE_POS) begin
                b = 1'b1;
            end else if (cur_bit[2:0] == `ETSM_SA4_POS) begin
                b = dl_bit;
            end else if (e_slot) begin
                case (cfg_ebit)
                    2'b00: begin
                        b       = !ln_q.pend;
                        consume = 1'b1;
                    end
                    2'b01:   b = 1'b0;
                    2'b10:   b = 1'b1;
                    default: b = dl_bit;
                endcase
            end
        end
        // a crc error arriving as one is reported is kept
        new_err       = (err_tgl_s != ln_q.err_seen);
        ln_d.err_seen = err_tgl_s;
        ln_d.pend     = new_err || (ln_q.pend && !consume);
        ln_d.bit_cnt  = cur_bit + 8'h01;
        ln_d.frm_cnt  = (cur_bit == `ETSM_LAST_BIT) ? cur_frm + 4'h1
                                                    : cur_frm;
        ln_d.sh       = {ln_q.sh[6:0], b};
        // alignment state: system timing waits for the first mark
        ln_d.tsel_prev = cfg_tsel;
        case (ln_q.state)
            etsm_pkg::ETSM_HUNT: begin
                if (!cfg_tsel || start) begin
                    ln_d.state = etsm_pkg::ETSM_RUN;
                end
            end
            etsm_pkg::ETSM_RUN: begin
                // a mark in the switching cycle keeps the frame running
                if (cfg_tsel && !ln_q.tsel_prev && !start) begin
                    ln_d.state = etsm_pkg::ETSM_HUNT;
                end
            end
            default: ln_d.state = etsm_pkg::ETSM_HUNT;
        endcase
        // framer timing drives the frame sync pin, and the multiframe pin at base rate only; system timing listens
        ln_d.fs_oe_n  = cfg_tsel;
        ln_d.mfs_oe_n = cfg_tsel || cfg_hs;
        ln_d.fs_out   = (ln_d.bit_cnt == 8'h00);
        ln_d.mfs_out  = (ln_d.bit_cnt == 8'h00) && (ln_d.frm_cnt == 4'h0);
        // link cannot stall: a refused byte is dropped and flagged
        ln_d.wr_valid = (ln_q.state == etsm_pkg::ETSM_RUN) &&
                        (cur_bit[2:0] == 3'h7);
        ln_d.wr_data  = {cur_bit[7:3] == 5'h00, ln_q.sh[6:0], b};
        if (ln_q.wr_valid && !fifo_ready) begin
            ln_d.ovf_tgl = ~ln_q.ovf_tgl;
        end
    end

    always_ff @(posedge tx_serial_clock_pin or posedge rst) begin
        if (rst) begin
            ln_q          <= '0;
            ln_q.fs_oe_n  <= 1'b1;
            ln_q.mfs_oe_n <= 1'b1;
        end else begin
            ln_q <= ln_d;
        end
    end

    assign tx_frame_sync_pin_out       = ln_q.fs_out;
    assign tx_frame_sync_pin_oe_n      = ln_q.fs_oe_n;
    assign tx_multiframe_sync_pin_out  = ln_q.mfs_out;
    assign tx_multiframe_sync_pin_oe_n = ln_q.mfs_oe_n;

    // ****************************************************************
    // octet buffer toward the system side
    // ****************************************************************
    etsm_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo (
        .wr_clk   (tx_serial_clock_pin),
        .rd_clk   (sys_clk),
        .rst      (rst),
        .wr_valid (ln_q.wr_valid),
        .wr_data  (ln_q.wr_data),
        .wr_ready (fifo_ready),
        .rd_valid (fifo_valid),
        .rd_data  (fifo_data),
        .rd_ready (frame_ready)
    );

    assign frame_valid = fifo_valid;
    assign frame_first = fifo_data[8];
    assign frame_data  = fifo_data[7:0];

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_e_live;
        ln_q.state == etsm_pkg::ETSM_RUN && !cfg_align && e_slot;
    endsequence

    sequence s_sys_frame;
        cfg_tsel && fs_s && !mf_mark;
    endsequence

    a_ebit_low_force: assert property (
        @(posedge tx_serial_clock_pin) disable iff (rst)
        s_e_live and (cfg_ebit == 2'b01) |=> (ln_q.sh[0] == 1'b0)
    ) else $error("e bit not forced low");

    a_ebit_high_force: assert property (
        @(posedge tx_serial_clock_pin) disable iff (rst)
        s_e_live and (cfg_ebit == 2'b10) |=> (ln_q.sh[0] == 1'b1)
    ) else $error("e bit not forced high");

    a_ebit_crc_report: assert property (
        @(posedge tx_serial_clock_pin) disable iff (rst)
        s_e_live and (cfg_ebit == 2'b00) and ln_q.pend and !new_err
        |=> (ln_q.sh[0] == 1'b0) && !ln_q.pend
    ) else $error("pending crc error not reported");

    a_ebit_dl_hdlc: assert property (
        @(posedge tx_serial_clock_pin) disable iff (rst)
        s_e_live and (cfg_ebit == 2'b11) and (cfg_dlink == 2'b01)
        |=> (ln_q.sh[0] == $past(hdlc_tx_dl_bit))
    ) else $error("e slot not fed from hdlc");

    a_fas_external: assert property (
        @(posedge tx_serial_clock_pin) disable iff (rst)
        cfg_align |=> (ln_q.sh[0] == $past(ser_s))
    ) else $error("external alignment bit altered");

    a_sys_frame_start: assert property (
        @(posedge tx_serial_clock_pin) disable iff (rst)
        cfg_tsel && fs_s |=> (ln_q.bit_cnt == 8'h01)
        && (ln_q.state == etsm_pkg::ETSM_RUN)
    ) else $error("frame not restarted on sync");

    a_base_mf_start: assert property (
        @(posedge tx_serial_clock_pin) disable iff (rst)
        cfg_tsel && !cfg_hs && mfs_s
        |=> (ln_q.frm_cnt == 4'h0) && (ln_q.bit_cnt == 8'h01)
    ) else $error("multiframe not restarted in base rate");

    a_fast_mf_option: assert property (
        @(posedge tx_serial_clock_pin) disable iff (rst)
        cfg_tsel && cfg_hs && cfg_mfopt && fs_s |=> (ln_q.frm_cnt == 4'h0)
    ) else $error("frame sync not taken as multiframe mark");

    a_base_opt_ignored: assert property (
        @(posedge tx_serial_clock_pin) disable iff (rst)
        s_sys_frame and (ln_q.bit_cnt != 8'h00) and (ln_q.frm_cnt != 4'hf)
        |=> (ln_q.frm_cnt == $past(ln_q.frm_cnt) + 4'h1)
    ) else $error("frame sync restarted multiframe");

    a_sync_pins_input: assert property (
        @(posedge tx_serial_clock_pin) disable iff (rst)
        cfg_tsel [*2] |-> ln_q.fs_oe_n && ln_q.mfs_oe_n
    ) else $error("sync pins driven under system timing");

    a_sync_mux_write: assert property (
        @(posedge sys_clk) disable iff (rst)
        cpu_cs && cpu_wr && (cpu_addr == `ETSM_SYNC_MUX_ADDR)
        |=> (sys_q.sync_mux == $past(cpu_wdata)) && cpu_rdy
    ) else $error("sync mux register not written");
endmodule

// ==== dv/etsm_partner.sv ====
`timescale 1ns/100ps
// system-side equipment: backplane clock, sync marks, serial payload
module etsm_partner (
    input  wire logic clk_en,
    input  wire logic run,
    output logic      lnk_clk,
    output logic      ser,
    output logic      fs,
    output logic      mfs
);
    int unsigned cnt;
    bit          q[$];

    // changes on the falling edge so the framer sees settled levels
    initial begin
        {lnk_clk, ser, fs, mfs} = 4'h0;
        cnt = 0;
        #7;
        forever begin
            #32;
            if (clk_en) begin
                lnk_clk = ~lnk_clk;
            end
            if (clk_en && run && !lnk_clk) begin
                fs = (cnt % 256) == 0;
                mfs = cnt == 0;
                ser = 1'($urandom);
                q.push_back(ser);
                cnt = (cnt + 1) % 4096;
            end
        end
    end
endmodule

// ==== dv/etsm_top_tb_top.sv ====
`timescale 1ns/100ps
module etsm_top_tb_top;
    logic        sys_clk, rst, cpu_cs, cpu_wr, cpu_rd, crc_err;
    logic        clk_en, run, hdlc, ovh, lclk, ser, fs_drv, mfs_drv, hs;
    logic        cpu_rdy, fs_out, fs_oe_n, mfs_out, mfs_oe_n;
    logic        frame_first, frame_valid, frame_ready;
    logic [11:0] cpu_addr;
    logic [7:0]  cpu_wdata, cpu_rdata, frame_data, rd;
    wire logic   fs_pin, mfs_pin;
    int          num_errors, n_checks;

    // pin level: device drives only while its enable is low
    assign fs_pin = fs_oe_n ? fs_drv : fs_out;
    assign mfs_pin = mfs_oe_n ? mfs_drv : mfs_out;

    always #10 sys_clk = ~sys_clk;

    etsm_partner i_partner (.clk_en(clk_en), .run(run), .lnk_clk(lclk),
        .ser(ser), .fs(fs_drv), .mfs(mfs_drv));

    etsm_top #(.FIFO_DEPTH(8)) i_dut (.sys_clk(sys_clk), .rst(rst),
        .cpu_cs(cpu_cs), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_rdy(cpu_rdy), .backplane_high_speed(hs),
        .rx_crc_error(crc_err), .tx_serial_clock_pin(lclk),
        .tx_serial_data_pin(ser), .tx_overhead_data_pin(ovh),
        .hdlc_tx_dl_bit(hdlc), .tx_frame_sync_pin_in(fs_pin),
        .tx_frame_sync_pin_out(fs_out), .tx_frame_sync_pin_oe_n(fs_oe_n),
        .tx_multiframe_sync_pin_in(mfs_pin),
        .tx_multiframe_sync_pin_out(mfs_out),
        .tx_multiframe_sync_pin_oe_n(mfs_oe_n), .frame_data(frame_data),
        .frame_first(frame_first), .frame_valid(frame_valid),
        .frame_ready(frame_ready));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one access; answer lands on the same edge that takes the strobe
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge sys_clk);
        cpu_cs <= 1'b1;
        cpu_wr <= w;
        cpu_rd <= !w;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge sys_clk);
        cpu_cs <= 1'b0;
        cpu_wr <= 1'b0;
        cpu_rd <= 1'b0;
        #1;
        chk("rdy", {7'h0, cpu_rdy}, 8'h01);
        rd = cpu_rdata;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk("rdata", rd, exp);
    endtask

    // octet taken at the edge where valid is seen with ready high
    task automatic take(output logic [7:0] d, output logic f);
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
            if (k > 3000) begin
                num_errors++;
                close_out();
            end
        end while (frame_valid !== 1'b1);
        d = frame_data;
        f = frame_first;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        int n, ts, f, m, cnt;
        logic [7:0] ex, d, cfg, v;
        logic [1:0] dls [4];
        logic fr, pend;
        dls = '{2'b00, 2'b10, 2'b11, 2'b01};
        {sys_clk, cpu_cs, cpu_wr, cpu_rd, crc_err, run} = 6'h0;
        {hs, hdlc, ovh, frame_ready, cpu_addr, cpu_wdata} = 24'h0;
        rst = 1'b1;
        clk_en = 1'b1;
        num_errors = 0;
        n_checks = 0;
        void'($urandom(32'ha8cb0342));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk(12'h109, 8'h00);
        v = 8'($urandom);
        acc(1'b1, 12'h109, v);
        acc(1'b1, 12'h108, ~v);
        rdchk(12'h109, v);
        rdchk(12'h000, 8'h00);
        acc(1'b1, 12'h109, 8'h00);
        repeat (200) @(posedge sys_clk);
        chk("oe_n", {6'h0, fs_oe_n, mfs_oe_n}, 8'h00);
        cfg = 8'h10;
        acc(1'b1, 12'h109, cfg);
        repeat (200) @(posedge sys_clk);
        chk("oe_n", {6'h0, fs_oe_n, mfs_oe_n}, 8'h03);
        // framer timing filled the buffer: drain it and clear the flag
        frame_ready <= 1'b1;
        repeat (20) @(posedge sys_clk);
        acc(1'b1, 12'h1f0, 8'h01);
        rdchk(12'h1f0, 8'h00);
        run <= 1'b1;
        pend = 1'b0;
        // five multiframes: e-bit sources 00..11, then external alignment
        for (n = 0; n < 2560; n++) begin
            ts = n % 32;
            f = (n / 32) % 16;
            m = n / 512;
            take(d, fr);
            for (int b = 0; b < 8; b++) ex[7-b] = i_partner.q.pop_front();
            if (ts == 0 && cfg[0] == 1'b0) begin
                if (f % 2 == 0) begin
                    ex[6:0] = 7'h1b;
                end else begin
                    ex[6] = 1'b1;
                    if (cfg[3:2] == 2'b01) ex[4] = hdlc;
                    if (cfg[3:2] == 2'b10) ex[4] = ovh;
                    if (f == 13 || f == 15) begin
                        case (cfg[7:6])
                            2'b00: ex[7] = !pend;
                            2'b01: ex[7] = 1'b0;
                            2'b10: ex[7] = 1'b1;
                            default: ex[7] = hdlc;
                        endcase
                        if (cfg[7:6] == 2'b00) pend = 1'b0;
                    end
                end
            end
            chk("octet", d, ex);
            chk("first", {7'h0, fr}, {7'h0, ts == 0});
            // reconfigure mid-frame, far from the next overhead slot
            if (ts == 16 && f == 0 && m > 0) begin
                cfg = m == 4 ? 8'h11 : {2'(m), 2'b01, dls[m], 2'b00};
                hdlc <= m == 3;
                ovh <= m == 1;
                acc(1'b1, 12'h109, cfg);
            end
            if (ts == 16 && f == 12 && m == 0) begin
                @(posedge sys_clk);
                crc_err <= 1'b1;
                @(posedge sys_clk);
                crc_err <= 1'b0;
                pend = 1'b1;
            end
        end
        // stall the sink until the buffer overflows, then drain it
        frame_ready <= 1'b0;
        repeat (600) @(posedge sys_clk);
        rdchk(12'h1f0, 8'h03);
        clk_en <= 1'b0;
        repeat (10) @(posedge sys_clk);
        frame_ready <= 1'b1;
        cnt = 0;
        repeat (40) begin
            @(posedge sys_clk);
            if (frame_valid === 1'b1) cnt++;
        end
        chk("drained", {7'h0, cnt >= 8}, 8'h01);
        rdchk(12'h1f0, 8'h01);
        acc(1'b1, 12'h1f0, 8'h01);
        rdchk(12'h1f0, 8'h00);
        // fast backplane: multiframe pin is a clock, frame sync may mark
        hs <= 1'b1;
        clk_en <= 1'b1;
        acc(1'b1, 12'h109, 8'h20);
        cnt = 0;
        repeat (1000) begin
            @(posedge sys_clk);
            if (fs_out === 1'b1) cnt++;
        end
        chk("fs_out", {7'h0, cnt > 0}, 8'h01);
        chk("oe_n", {6'h0, fs_oe_n, mfs_oe_n}, 8'h01);
        acc(1'b1, 12'h109, 8'h30);
        repeat (900) @(posedge sys_clk);
        chk("oe_n", {6'h0, fs_oe_n, mfs_oe_n}, 8'h03);
        close_out();
    end
endmodule
